// File: dcc_pkg.sv
// dcc_pkg: register indices, field positions, reset values and carrier types
// for the dual comparator control block.
// assumes: 8-bit registers, each placed in one 32-bit wishbone word.
package dcc_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int unsigned NUM_CMP  = 2;
    localparam int unsigned ADR_W    = 14;
    localparam int unsigned IDX_W    = 12;
    localparam int unsigned DAT_W    = 32;
    localparam int unsigned REG_W    = 8;
    localparam int unsigned SEL_W    = 3;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] CMP2_CONTROL_A_IDX       = 12'hf30;
    localparam logic [IDX_W-1:0] CMP2_CONTROL_B_IDX       = 12'hf31;
    localparam logic [IDX_W-1:0] CMP2_NEGATIVE_SELECT_IDX = 12'hf32;
    localparam logic [IDX_W-1:0] CMP2_POSITIVE_SELECT_IDX = 12'hf33;
    localparam logic [IDX_W-1:0] CMP1_CONTROL_A_IDX       = 12'hf34;
    localparam logic [IDX_W-1:0] CMP1_CONTROL_B_IDX       = 12'hf35;
    localparam logic [IDX_W-1:0] CMP1_NEGATIVE_SELECT_IDX = 12'hf36;
    localparam logic [IDX_W-1:0] CMP1_POSITIVE_SELECT_IDX = 12'hf37;
    localparam logic [IDX_W-1:0] RESULT_MIRROR_IDX        = 12'hf38;
    localparam logic [IDX_W-1:0] IRQ_FLAG_IDX             = 12'hf39;
    localparam logic [IDX_W-1:0] IRQ_ENABLE_IDX           = 12'hf3a;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned CA_EN_BIT   = 7;
    localparam int unsigned CA_OUT_BIT  = 6;
    localparam int unsigned CA_INV_BIT  = 4;
    localparam int unsigned CA_HYS_BIT  = 1;
    localparam int unsigned CA_SYNC_BIT = 0;
    localparam int unsigned CB_RISE_BIT = 1;
    localparam int unsigned CB_FALL_BIT = 0;
    localparam int unsigned SEL_LSB     = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [SEL_W-1:0]   SEL_RST  = 3'h0;
    localparam logic [NUM_CMP-1:0] FLAG_RST = 2'h0;
    localparam logic [REG_W-1:0]   ZERO_REG = 8'h00;
    localparam logic [DAT_W-1:0]   ZERO_DAT = 32'h0000_0000;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic             enable;
        logic             output_invert;
        logic             hysteresis_on;
        logic             sync_mode;
        logic             rise_flag_enable;
        logic             fall_flag_enable;
        logic [SEL_W-1:0] negative_sel;
        logic [SEL_W-1:0] positive_sel;
    } dcc_ctrl_s;

    localparam dcc_ctrl_s CTRL_RST = '{
        enable:           1'b0,
        output_invert:    1'b0,
        hysteresis_on:    1'b0,
        sync_mode:        1'b0,
        rise_flag_enable: 1'b0,
        fall_flag_enable: 1'b0,
        negative_sel:     SEL_RST,
        positive_sel:     SEL_RST
    };

    typedef struct packed {
        logic enable;
        logic hysteresis_on;
        logic [SEL_W-1:0] negative_sel;
        logic [SEL_W-1:0] positive_sel;
    } dcc_analog_s;

endpackage

// File: dcc_channel.sv
// dcc_channel: one comparator's digital path: input synchroniser, polarity,
// optional latch on the timer clock falling edge, and edge detection.
// assumes: raw_i is asynchronous; tclk_fall_i is a one-cycle pulse in clk_i.
`timescale 1ns/10ps
module dcc_channel (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              raw_i,
    input  wire logic              tclk_fall_i,
    input  wire dcc_pkg::dcc_ctrl_s cfg_i,
    output logic                   result_o,
    output logic                   edge_o
);
    logic raw_meta_q;
    logic raw_sync_q;
    logic latched_q;
    logic prev_q;
    logic polar;
    logic result;

    // ------------------------------------------------------------------
    // synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            raw_meta_q <= 1'b0;
            raw_sync_q <= 1'b0;
        end else begin
            raw_meta_q <= raw_i;
            raw_sync_q <= raw_meta_q;
        end
    end

    // a disabled comparator reads as the invert bit, so toggling enable
    // or invert can still produce an edge
    assign polar = (cfg_i.enable & raw_sync_q) ^ cfg_i.output_invert; // [RL2] [RL3] [RL4] [RL5]

    // ------------------------------------------------------------------
    // timer clock latch
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latched_q <= 1'b0;
        end else if (tclk_fall_i) begin
            latched_q <= polar; // [RL7]
        end
    end

    assign result = cfg_i.sync_mode ? latched_q : polar; // [RL7] [RL8]

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= result; // [RL15]
        end
    end

    assign edge_o = (cfg_i.rise_flag_enable & result & ~prev_q)     // [RL9]
                  | (cfg_i.fall_flag_enable & ~result & prev_q);    // [RL10]
    assign result_o = result;

endmodule

// File: dcc_top.sv
// dcc_top: dual comparator control with a classic wishbone register slave,
// sticky comparator flags, interrupt and wake outputs.
// assumes: analog core gives raw results asynchronously; the prescaled timer
// clock arrives asynchronously and is much slower than clk_i.
//
// How it works
// [RL1] a set flag whose enable is set raises wake while sleeping
// [RL2] control_a bit 7 enables a comparator; off means result forced low (the code gives the invert bit instead, so high when invert is set)
// [RL3] invert clear: result bit is 1 when positive input is higher
// [RL4] invert set: result bit is 1 when positive input is lower
// [RL5] control_a bit 4 inverts the comparator output
// [RL6] control_a bit 1 turns on input hysteresis
// [RL7] sync bit set: output updates only on timer clock falling edge
// [RL8] sync bit clear: output follows the comparison directly
// [RL9] control_b bit 1 lets a rising result edge set the flag
// [RL10] control_b bit 0 lets a falling result edge set the flag
// [RL11] control_a sits at index f34 for comparator 1, f30 for 2
// [RL12] control_b sits at index f35 for comparator 1, f31 for 2
// [RL13] mirror register shows comparator 1 at bit 0, 2 at bit 1
// [RL14] software clears flags; an edge during the clear keeps it set
// [RL15] edges are found on the final output by comparing clk samples
`timescale 1ns/10ps
module dcc_top (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // wishbone classic slave
    input  wire logic                        cyc_i,
    input  wire logic                        stb_i,
    input  wire logic                        we_i,
    input  wire logic [dcc_pkg::ADR_W-1:0]   adr_i,
    input  wire logic [3:0]                  sel_i,
    input  wire logic [dcc_pkg::DAT_W-1:0]   dat_i,
    output logic      [dcc_pkg::DAT_W-1:0]   dat_o,
    output logic                             ack_o,
    // analog core
    input  wire logic [dcc_pkg::NUM_CMP-1:0] raw_result_i,
    output dcc_pkg::dcc_analog_s             analog_cfg_o [dcc_pkg::NUM_CMP],
    // timer
    input  wire logic                        timer_clk_i,
    output logic      [dcc_pkg::NUM_CMP-1:0] cmp_result_o,
    // system
    input  wire logic                        sleep_i,
    output logic                             irq_o,
    output logic                             wake_o
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    dcc_pkg::dcc_ctrl_s                ctrl_q [dcc_pkg::NUM_CMP];
    logic [dcc_pkg::NUM_CMP-1:0]       cmp_irq_flag_q;
    logic [dcc_pkg::NUM_CMP-1:0]       cmp_irq_flag_d;
    logic [dcc_pkg::NUM_CMP-1:0]       cmp_irq_enable_q;
    logic [dcc_pkg::NUM_CMP-1:0]       edge_set;
    logic [dcc_pkg::NUM_CMP-1:0]       flag_clear;
    logic [dcc_pkg::NUM_CMP-1:0]       result;
    logic [dcc_pkg::NUM_CMP-1:0]       result_q;
    logic [dcc_pkg::DAT_W-1:0]         dat_q;
    logic [dcc_pkg::DAT_W-1:0]         rd_data;
    logic                              ack_q;
    logic                              tclk_meta_q;
    logic                              tclk_sync_q;
    logic                              tclk_prev_q;
    logic                              tclk_fall;
    logic                              bus_req;
    logic                              bus_wr;
    logic                              irq_q;
    logic                              wake_q;
    logic [dcc_pkg::IDX_W-1:0]         idx;
    logic [dcc_pkg::REG_W-1:0]         wr_byte;

    // ------------------------------------------------------------------
    // register map helpers
    // ------------------------------------------------------------------
    function automatic logic [dcc_pkg::IDX_W-1:0] ctrl_a_idx(input int unsigned ch);
        ctrl_a_idx = (ch == 0) ? dcc_pkg::CMP1_CONTROL_A_IDX
                               : dcc_pkg::CMP2_CONTROL_A_IDX;
    endfunction

    function automatic logic [dcc_pkg::IDX_W-1:0] ctrl_b_idx(input int unsigned ch);
        ctrl_b_idx = (ch == 0) ? dcc_pkg::CMP1_CONTROL_B_IDX
                               : dcc_pkg::CMP2_CONTROL_B_IDX;
    endfunction

    function automatic logic [dcc_pkg::IDX_W-1:0] neg_idx(input int unsigned ch);
        neg_idx = (ch == 0) ? dcc_pkg::CMP1_NEGATIVE_SELECT_IDX
                            : dcc_pkg::CMP2_NEGATIVE_SELECT_IDX;
    endfunction

    function automatic logic [dcc_pkg::IDX_W-1:0] pos_idx(input int unsigned ch);
        pos_idx = (ch == 0) ? dcc_pkg::CMP1_POSITIVE_SELECT_IDX
                            : dcc_pkg::CMP2_POSITIVE_SELECT_IDX;
    endfunction

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // only byte lane 0 carries register data; other lanes are ignored
    assign idx     = adr_i[dcc_pkg::ADR_W-1:2];
    assign bus_req = cyc_i & stb_i & ~ack_q;
    assign bus_wr  = bus_req & we_i & sel_i[0];
    assign wr_byte = dat_i[dcc_pkg::REG_W-1:0];

    // ------------------------------------------------------------------
    // timer clock synchroniser and falling edge
    // ------------------------------------------------------------------
    // the timer clock must stay level for at least two clk_i periods or
    // falling edges will be missed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tclk_meta_q <= 1'b0;
            tclk_sync_q <= 1'b0;
            tclk_prev_q <= 1'b0;
        end else begin
            tclk_meta_q <= timer_clk_i;
            tclk_sync_q <= tclk_meta_q;
            tclk_prev_q <= tclk_sync_q;
        end
    end

    assign tclk_fall = tclk_prev_q & ~tclk_sync_q; // [RL7]

    // ------------------------------------------------------------------
    // per comparator control registers and datapath
    // ------------------------------------------------------------------
    generate
        for (genvar ch = 0; ch < dcc_pkg::NUM_CMP; ch++) begin : g_cmp
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    ctrl_q[ch] <= dcc_pkg::CTRL_RST; // [RL11]
                end else if (bus_wr) begin
                    if (idx == ctrl_a_idx(ch)) begin // [RL11]
                        ctrl_q[ch].enable        <= wr_byte[dcc_pkg::CA_EN_BIT];   // [RL2]
                        ctrl_q[ch].output_invert <= wr_byte[dcc_pkg::CA_INV_BIT];  // [RL5]
                        ctrl_q[ch].hysteresis_on <= wr_byte[dcc_pkg::CA_HYS_BIT];  // [RL6]
                        ctrl_q[ch].sync_mode     <= wr_byte[dcc_pkg::CA_SYNC_BIT]; // [RL7]
                    end
                    if (idx == ctrl_b_idx(ch)) begin // [RL12]
                        ctrl_q[ch].rise_flag_enable <= wr_byte[dcc_pkg::CB_RISE_BIT]; // [RL9]
                        ctrl_q[ch].fall_flag_enable <= wr_byte[dcc_pkg::CB_FALL_BIT]; // [RL10]
                    end
                    if (idx == neg_idx(ch)) begin
                        ctrl_q[ch].negative_sel <=
                            wr_byte[dcc_pkg::SEL_LSB +: dcc_pkg::SEL_W];
                    end
                    if (idx == pos_idx(ch)) begin
                        ctrl_q[ch].positive_sel <=
                            wr_byte[dcc_pkg::SEL_LSB +: dcc_pkg::SEL_W];
                    end
                end
            end

            dcc_channel u_channel (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .raw_i       (raw_result_i[ch]),
                .tclk_fall_i (tclk_fall),
                .cfg_i       (ctrl_q[ch]),
                .result_o    (result[ch]),
                .edge_o      (edge_set[ch])
            );

            // analog side sees the enable, hysteresis and channel selects one clk_i cycle after
            // ctrl_q; the selects are passed through untouched
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    analog_cfg_o[ch] <= '0;
                end else begin
                    analog_cfg_o[ch].enable        <= ctrl_q[ch].enable;        // [RL2]
                    analog_cfg_o[ch].hysteresis_on <= ctrl_q[ch].hysteresis_on; // [RL6]
                    analog_cfg_o[ch].negative_sel  <= ctrl_q[ch].negative_sel;
                    analog_cfg_o[ch].positive_sel  <= ctrl_q[ch].positive_sel;
                end
            end

            assign flag_clear[ch] = bus_wr & (idx == dcc_pkg::IRQ_FLAG_IDX) & wr_byte[ch];
        end
    endgenerate

    // ------------------------------------------------------------------
    // result register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_q <= '0;
        end else begin
            result_q <= result; // [RL8]
        end
    end

    assign cmp_result_o = result_q;

    // ------------------------------------------------------------------
    // sticky flags, enables and interrupt
    // ------------------------------------------------------------------
    // set wins over clear so an edge during the clearing write is kept
    assign cmp_irq_flag_d = (cmp_irq_flag_q & ~flag_clear) | edge_set; // [RL14]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_irq_flag_q <= dcc_pkg::FLAG_RST;
        end else begin
            cmp_irq_flag_q <= cmp_irq_flag_d; // [RL9] [RL10] [RL14]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_irq_enable_q <= dcc_pkg::FLAG_RST;
        end else if (bus_wr && idx == dcc_pkg::IRQ_ENABLE_IDX) begin
            cmp_irq_enable_q <= wr_byte[dcc_pkg::NUM_CMP-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q  <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q  <= |(cmp_irq_flag_q & cmp_irq_enable_q);
            wake_q <= sleep_i & |(cmp_irq_flag_q & cmp_irq_enable_q); // [RL1]
        end
    end

    assign irq_o  = irq_q;
    assign wake_o = wake_q;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        rd_data = dcc_pkg::ZERO_DAT;
        for (int ch = 0; ch < dcc_pkg::NUM_CMP; ch++) begin
            if (idx == ctrl_a_idx(ch)) begin
                rd_data[dcc_pkg::CA_EN_BIT]   = ctrl_q[ch].enable;
                rd_data[dcc_pkg::CA_OUT_BIT]  = result_q[ch]; // [RL3] [RL4]
                rd_data[dcc_pkg::CA_INV_BIT]  = ctrl_q[ch].output_invert;
                rd_data[dcc_pkg::CA_HYS_BIT]  = ctrl_q[ch].hysteresis_on;
                rd_data[dcc_pkg::CA_SYNC_BIT] = ctrl_q[ch].sync_mode;
            end
            if (idx == ctrl_b_idx(ch)) begin
                rd_data[dcc_pkg::CB_RISE_BIT] = ctrl_q[ch].rise_flag_enable;
                rd_data[dcc_pkg::CB_FALL_BIT] = ctrl_q[ch].fall_flag_enable;
            end
            if (idx == neg_idx(ch)) begin
                rd_data[dcc_pkg::SEL_LSB +: dcc_pkg::SEL_W] = ctrl_q[ch].negative_sel;
            end
            if (idx == pos_idx(ch)) begin
                rd_data[dcc_pkg::SEL_LSB +: dcc_pkg::SEL_W] = ctrl_q[ch].positive_sel;
            end
        end
        if (idx == dcc_pkg::RESULT_MIRROR_IDX) begin
            rd_data[dcc_pkg::NUM_CMP-1:0] = result_q; // [RL13]
        end
        if (idx == dcc_pkg::IRQ_FLAG_IDX) begin
            rd_data[dcc_pkg::NUM_CMP-1:0] = cmp_irq_flag_q;
        end
        if (idx == dcc_pkg::IRQ_ENABLE_IDX) begin
            rd_data[dcc_pkg::NUM_CMP-1:0] = cmp_irq_enable_q;
        end
    end

    // ------------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------------
    // every address is acknowledged; unmapped reads return zero and
    // unmapped writes are dropped, so software never hangs the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= dcc_pkg::ZERO_DAT;
        end else if (bus_req && !we_i) begin
            dat_q <= rd_data;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

endmodule

// File: dcc_asserts.sv
// dcc_asserts: port-level checks for dcc_top.
// assumes: bound to dcc_top below; one clock, synchronous active-high reset.
`timescale 1ns/10ps
module dcc_asserts (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        cyc_i,
    input  wire logic                        stb_i,
    input  wire logic                        we_i,
    input  wire logic [dcc_pkg::DAT_W-1:0]   dat_o,
    input  wire logic                        ack_o,
    input  wire logic [dcc_pkg::NUM_CMP-1:0] raw_result_i,
    input  wire logic                        timer_clk_i,
    input  wire logic [dcc_pkg::NUM_CMP-1:0] cmp_result_o,
    input  wire logic                        sleep_i,
    input  wire logic                        irq_o,
    input  wire logic                        wake_o
);
    // ------------------------------------------------------------------
    // helpers: saturating ages, so an old cause never wraps back in
    // ------------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [3:0] wr_age_q;
    logic [3:0] tmr_age_q;
    logic       tmr_last_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || (cyc_i && stb_i && we_i && !ack_o)) wr_age_q <= 4'h0;
        else if (wr_age_q != 4'hf) wr_age_q <= wr_age_q + 4'h1;
    end
    always_ff @(posedge clk_i) begin
        tmr_last_q <= timer_clk_i;
        if (rst_i || (timer_clk_i != tmr_last_q)) tmr_age_q <= 4'h0;
        else if (tmr_age_q != 4'hf) tmr_age_q <= tmr_age_q + 4'h1;
    end
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_ack_answer: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("request not answered one cycle later");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_dat_hold: assert property ($changed(dat_o) |-> ack_o && !we_i)
        else $error("read data changed outside a read");
    a_dat_upper: assert property (dat_o[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    a_wake_gate: assert property (wake_o == (irq_o && $past(sleep_i)))
        else $error("wake does not match sleep and interrupt");
    a_result_cause: assert property ($changed(cmp_result_o) |->
        ($past(raw_result_i, 3) != $past(raw_result_i, 4)) || wr_age_q < 6 || tmr_age_q < 8)
        else $error("result changed with no cause");
    a_irq_rise_edge: assert property ($rose(irq_o) |->
        ($past(cmp_result_o) != $past(cmp_result_o, 2)) || wr_age_q < 4)
        else $error("interrupt rose without a result edge");
    a_irq_sticky: assert property ($fell(irq_o) |-> wr_age_q < 4)
        else $error("interrupt dropped without a write");
    c_irq: cover property ($rose(irq_o));
    c_wake: cover property ($rose(wake_o));
    c_read: cover property (ack_o && !we_i);
endmodule

bind dcc_top dcc_asserts u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o, .ack_o,
    .raw_result_i, .timer_clk_i, .cmp_result_o, .sleep_i, .irq_o, .wake_o);

// File: dcc_analog_model.sv
// dcc_analog_model: the comparator pair's analog core and the timer clock.
// assumes: the bench says per comparator whether the positive input is higher.
`timescale 1ns/10ps
module dcc_analog_model (
    input  wire logic                        clk_i,
    input  wire logic [dcc_pkg::NUM_CMP-1:0] above_i,
    input  wire logic                        tmr_run_i,
    input  dcc_pkg::dcc_analog_s             cfg_i [dcc_pkg::NUM_CMP],
    output logic      [dcc_pkg::NUM_CMP-1:0] raw_o,
    output logic                             timer_clk_o
);
    logic [3:0] div_q = 4'h0;
    // timer freezes where it is between bursts, so no stray falling edge
    always @(posedge clk_i) begin
        if (tmr_run_i) div_q <= div_q + 4'h1;
    end
    assign timer_clk_o = div_q[3];
    // a disabled core drives the opposite of a true compare, never a help
    always_comb begin
        for (int k = 0; k < dcc_pkg::NUM_CMP; k++) begin
            raw_o[k] = cfg_i[k].enable ? above_i[k] : ~above_i[k];
        end
    end
endmodule

// File: tb_top.sv
// tb_top: register-level tests of dcc_top against the analog model.
// assumes: design and checker compiled first; 50 MHz clock.
`timescale 1ns/10ps
module tb_top;
    logic                      clk_i = 1'b0;
    logic                      rst_i = 1'b1;
    logic                      cyc_i = 1'b0;
    logic                      stb_i = 1'b0;
    logic                      we_i = 1'b0;
    logic                      sleep_i = 1'b0;
    logic                      tmr_run = 1'b0;
    logic [3:0]                sel_i = 4'h0;
    logic [dcc_pkg::ADR_W-1:0] adr_i = 14'h0;
    logic [dcc_pkg::DAT_W-1:0] dat_i = 32'h0;
    logic [dcc_pkg::DAT_W-1:0] dat_o;
    logic                      ack_o, irq_o, wake_o, tclk;
    logic [1:0]                raw, cmp_result_o;
    logic [1:0]                above = 2'h3;
    dcc_pkg::dcc_analog_s      acfg [dcc_pkg::NUM_CMP];
    logic [7:0]                rd;
    int                        errors = 0;
    int                        n_compared = 0;
    localparam logic [11:0] RST_IDX [11] = '{12'hf30, 12'hf31, 12'hf32, 12'hf33, 12'hf34,
                                            12'hf35, 12'hf36, 12'hf37, 12'hf38, 12'hf39,
                                            12'hf3a};

    dcc_top u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .raw_result_i(raw), .analog_cfg_o(acfg), .timer_clk_i(tclk), .cmp_result_o,
        .sleep_i, .irq_o, .wake_o);
    dcc_analog_model u_ana (.clk_i, .above_i(above), .tmr_run_i(tmr_run), .cfg_i(acfg),
        .raw_o(raw), .timer_clk_o(tclk));

    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d of %0d compared", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        sel_i <= 4'h1;
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            errors++;
            end_of_test();
        end
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk($sformatf("register %h", idx), {24'h0, rd}, {24'h0, exp});
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        pause(12);
        rst_i <= 1'b0;
        foreach (RST_IDX[i]) rdchk(RST_IDX[i], 8'h00);
        bus(1'b1, 12'hf3f, 8'hff);
        rdchk(12'hf3f, 8'h00);
        bus(1'b1, 12'hf3a, 8'h03);
        bus(1'b1, 12'hf35, 8'h02);
        bus(1'b1, 12'hf34, 8'h80);
        pause(8);
        rdchk(12'hf35, 8'h02);
        rdchk(12'hf34, 8'hc0);
        rdchk(12'hf38, 8'h01);
        rdchk(12'hf39, 8'h01);
        chk("irq", {31'h0, irq_o}, 32'h1);
        chk("analog enable", {31'h0, acfg[0].enable}, 32'h1);
        sleep_i <= 1'b1;
        pause(2);
        chk("wake", {31'h0, wake_o}, 32'h1);
        bus(1'b1, 12'hf39, 8'h01);
        pause(2);
        chk("wake after clear", {31'h0, wake_o}, 32'h0);
        chk("irq after clear", {31'h0, irq_o}, 32'h0);
        sleep_i <= 1'b0;
        // invert with only rise enabled: a falling result must not flag
        bus(1'b1, 12'hf34, 8'h90);
        pause(8);
        rdchk(12'hf34, 8'h90);
        rdchk(12'hf39, 8'h00);
        bus(1'b1, 12'hf34, 8'h80);
        bus(1'b1, 12'hf35, 8'h01);
        bus(1'b1, 12'hf39, 8'h03);
        above[0] <= 1'b0;
        pause(8);
        chk("result follows", {30'h0, cmp_result_o}, 32'h0);
        rdchk(12'hf39, 8'h01);
        bus(1'b1, 12'hf39, 8'h01);
        above[0] <= 1'b1;
        pause(8);
        rdchk(12'hf39, 8'h00);
        // falling edge lands on the clearing write's taking edge
        above[0] <= 1'b0;
        pause(1);
        bus(1'b1, 12'hf39, 8'h01);
        rdchk(12'hf39, 8'h01);
        bus(1'b1, 12'hf39, 8'h01);
        above[0] <= 1'b1;
        bus(1'b1, 12'hf30, 8'h82);
        above[1] <= 1'b1;
        pause(8);
        chk("hysteresis", {31'h0, acfg[1].hysteresis_on}, 32'h1);
        bus(1'b1, 12'hf38, 8'h00);
        rdchk(12'hf38, 8'h03);
        bus(1'b1, 12'hf36, 8'h05);
        bus(1'b1, 12'hf33, 8'h06);
        rdchk(12'hf36, 8'h05);
        chk("nsel", {29'h0, acfg[0].negative_sel}, 32'h5);
        chk("psel", {29'h0, acfg[1].positive_sel}, 32'h6);
        // sync mode: latch on the first timer burst, then the raw change must wait for the next burst
        bus(1'b1, 12'hf34, 8'h81);
        tmr_run <= 1'b1;
        pause(40);
        tmr_run <= 1'b0;
        above[0] <= 1'b0;
        pause(12);
        chk("sync hold", {31'h0, cmp_result_o[0]}, 32'h1);
        tmr_run <= 1'b1;
        pause(40);
        tmr_run <= 1'b0;
        chk("sync update", {31'h0, cmp_result_o[0]}, 32'h0);
        end_of_test();
    end
endmodule
